//--- include/exc_state_defines.vh
// register map, field positions and constants for the exception state block
`ifndef EXC_STATE_DEFINES_VH
`define EXC_STATE_DEFINES_VH

// word addresses (byte address = 4 * index)
`define ADDR_ICS        4'h0
`define ADDR_ARC        4'h1
`define ADDR_IRQ_STAT   4'h2
`define ADDR_IRQ_MASK   4'h3

// state register fields
`define BIT_DSVC_SET    28
`define BIT_DSVC_CLR    27
`define BIT_TICK_SET    26
`define BIT_TICK_CLR    25
`define BIT_IRQ_PEND    22
`define FLD_PEND_HI     17
`define FLD_PEND_LO     12
`define FLD_ACT_HI      5
`define FLD_ACT_LO      0

// reset control fields
`define FLD_KEY_HI      31
`define FLD_KEY_LO      16
`define ARC_KEY         16'h05fa
`define BIT_RST_REQ     2

// exception numbers
`define EXC_DSVC        6'h0e
`define EXC_TICK        6'h0f
`define EXC_IRQ_BASE    6'h10

// interrupt status bits
`define IRQ_W           3
`define IRQ_TICK_SET    0
`define IRQ_DSVC_SET    1
`define IRQ_RST_REQ     2

`endif

//--- rtl/pend_flag.v
// one set/clear pending flag
`timescale 1ns/1ps
`default_nettype none
module pend_flag (
	// clock and reset
	input  wire sys_clk_i,
	input  wire rst_i,
	// controls
	input  wire set_i,
	input  wire clr_i,
	// state
	output reg  pend_o
);
	// set wins over clear so no request is lost
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			pend_o <= 1'b0;
		end else if (set_i) begin
			pend_o <= 1'b1;
		end else if (clr_i) begin
			pend_o <= 1'b0;
		end
	end
endmodule // pend_flag
`default_nettype wire

//--- rtl/pend_select.v
// priority pick of highest pending enabled exception
`timescale 1ns/1ps
`default_nettype none
`include "exc_state_defines.vh"
module pend_select (
	// pending sources
	input  wire        tick_pend_i,
	input  wire        dsvc_pend_i,
	input  wire [31:0] irq_pend_i,
	input  wire [31:0] irq_en_i,
	// result
	output reg  [5:0]  exc_num_o
);
	integer i;
	reg [31:0] live;
	// fixed order: deferred, tick, then lowest irq index
	always @* begin
		live      = irq_pend_i & irq_en_i;
		exc_num_o = 6'h00;
		for (i = 31; i >= 0; i = i - 1) begin
			if (live[i]) begin
				exc_num_o = `EXC_IRQ_BASE + i[5:0];
			end
		end
		if (tick_pend_i) begin
			exc_num_o = `EXC_TICK;
		end
		if (dsvc_pend_i) begin
			exc_num_o = `EXC_DSVC;
		end
	end
endmodule // pend_select
`default_nettype wire

//--- rtl/exc_state_ctrl.v
// exception pending and active state registers behind avalon-mm
`timescale 1ns/1ps
`default_nettype none
`include "exc_state_defines.vh"
module exc_state_ctrl (
	// clock and reset
	input  wire        sys_clk_i,
	input  wire        rst_i,
	// avalon-mm slave
	input  wire [3:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output reg  [31:0] avs_readdata_o,
	output reg         avs_waitrequest_o,
	// core side
	input  wire [5:0]  core_prog_status_i,
	input  wire [31:0] core_irq_pend_i,
	input  wire [31:0] core_irq_en_i,
	input  wire        core_tick_ack_i,
	input  wire        core_dsvc_ack_i,
	output reg         tick_pend_o,
	output reg         dsvc_pend_o,
	output reg         sys_reset_req_o,
	// interrupt
	output reg         irq_o
);
	wire        wr_go;
	wire        rd_go;
	wire        tick_pend;
	wire        dsvc_pend;
	wire [5:0]  pend_num;
	wire        key_ok;
	wire        full_word;
	reg  [5:0]  pend_num_reg;
	reg  [5:0]  act_num_reg;
	reg         irq_any_reg;
	reg  [`IRQ_W-1:0] stat_reg;
	reg  [`IRQ_W-1:0] stat_next;
	reg  [`IRQ_W-1:0] mask_reg;
	reg  [31:0] rdata_next;
	wire [`IRQ_W-1:0] ev;

	// one wait cycle: request taken when waitrequest drops
	assign wr_go     = avs_write_i & ~avs_waitrequest_o;
	assign rd_go     = avs_read_i & ~avs_waitrequest_o;
	assign full_word = &avs_byteenable_i;
	assign key_ok    = (avs_writedata_i[`FLD_KEY_HI:`FLD_KEY_LO] == `ARC_KEY) & full_word;

	wire ics_wr = wr_go & (avs_address_i == `ADDR_ICS) & avs_byteenable_i[3];
	wire arc_wr = wr_go & (avs_address_i == `ADDR_ARC) & key_ok;

	// waitrequest toggles low for one cycle per request
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
			avs_waitrequest_o <= 1'b0;
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end

	pend_flag u_tick (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.set_i     (ics_wr & avs_writedata_i[`BIT_TICK_SET]),
		.clr_i     ((ics_wr & avs_writedata_i[`BIT_TICK_CLR]) | core_tick_ack_i),
		.pend_o    (tick_pend)
	);

	pend_flag u_dsvc (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.set_i     (ics_wr & avs_writedata_i[`BIT_DSVC_SET]),
		.clr_i     ((ics_wr & avs_writedata_i[`BIT_DSVC_CLR]) | core_dsvc_ack_i),
		.pend_o    (dsvc_pend)
	);

	pend_select u_sel (
		.tick_pend_i (tick_pend),
		.dsvc_pend_i (dsvc_pend),
		.irq_pend_i  (core_irq_pend_i),
		.irq_en_i    (core_irq_en_i),
		.exc_num_o   (pend_num)
	);

	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			pend_num_reg <= 6'h00;
			act_num_reg  <= 6'h00;
			irq_any_reg  <= 1'b0;
			tick_pend_o  <= 1'b0;
			dsvc_pend_o  <= 1'b0;
		end else begin
			pend_num_reg <= pend_num;
			act_num_reg  <= core_prog_status_i;
			irq_any_reg  <= (|core_irq_pend_i) | tick_pend | dsvc_pend;
			tick_pend_o  <= tick_pend;
			dsvc_pend_o  <= dsvc_pend;
		end
	end

	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			sys_reset_req_o <= 1'b0;
		end else begin
			sys_reset_req_o <= arc_wr & avs_writedata_i[`BIT_RST_REQ];
		end
	end

	// events for the sticky status
	assign ev[`IRQ_TICK_SET] = ics_wr & avs_writedata_i[`BIT_TICK_SET];
	assign ev[`IRQ_DSVC_SET] = ics_wr & avs_writedata_i[`BIT_DSVC_SET];
	assign ev[`IRQ_RST_REQ]  = arc_wr & avs_writedata_i[`BIT_RST_REQ];

	// write one to clear; a new event in the same cycle wins
	always @* begin
		stat_next = stat_reg;
		if (wr_go & (avs_address_i == `ADDR_IRQ_STAT) & avs_byteenable_i[0]) begin
			stat_next = stat_reg & ~avs_writedata_i[`IRQ_W-1:0];
		end
		stat_next = stat_next | ev;
	end

	// status, mask and interrupt line
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			stat_reg <= {`IRQ_W{1'b0}};
			mask_reg <= {`IRQ_W{1'b0}};
			irq_o    <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			if (wr_go & (avs_address_i == `ADDR_IRQ_MASK) & avs_byteenable_i[0]) begin
				mask_reg <= avs_writedata_i[`IRQ_W-1:0];
			end
			irq_o <= |(stat_next & mask_reg);
		end
	end

	// read mux; reserved and write-only bits read zero
	always @* begin
		rdata_next = 32'h0000_0000;
		if (avs_address_i == `ADDR_ICS) begin
			rdata_next[`BIT_DSVC_SET]               = dsvc_pend;
			rdata_next[`BIT_TICK_SET]               = tick_pend;
			rdata_next[`BIT_IRQ_PEND]               = irq_any_reg;
			rdata_next[`FLD_PEND_HI:`FLD_PEND_LO]   = pend_num_reg;
			rdata_next[`FLD_ACT_HI:`FLD_ACT_LO]     = act_num_reg;
		end else if (avs_address_i == `ADDR_ARC) begin
			rdata_next = 32'h0000_0000;
		end else if (avs_address_i == `ADDR_IRQ_STAT) begin
			rdata_next[`IRQ_W-1:0] = stat_reg;
		end else if (avs_address_i == `ADDR_IRQ_MASK) begin
			rdata_next[`IRQ_W-1:0] = mask_reg;
		end
	end

	// read data registered with the answering edge
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i & avs_waitrequest_o) begin
			avs_readdata_o <= rdata_next;
		end
	end
endmodule // exc_state_ctrl
`default_nettype wire

//--- testbench/exc_state_chk.sv
// checker for the exception state block ports
`timescale 1ns/1ps
`default_nettype none
module exc_state_chk (
	// bus and core side, grouped to stay short
	input wire logic        sys_clk_i, rst_i, avs_read_i, avs_write_i,
	input wire logic [3:0]  avs_address_i, avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i, avs_readdata_o,
	input wire logic        avs_waitrequest_o, tick_pend_o, dsvc_pend_o, sys_reset_req_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// accepted accesses only
	wire        wr = avs_write_i && !avs_waitrequest_o;
	wire        rd = avs_read_i && !avs_waitrequest_o;
	wire        ics = wr && avs_address_i == 4'h0 && avs_byteenable_i[3];
	wire        arc = wr && avs_address_i == 4'h1;
	wire [31:0] d = avs_writedata_i;
	AST_ANSWER: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("no answer");
	AST_ONE_LOW: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait low");
	AST_TSET: assert property (ics && d[26] |-> ##[1:3] tick_pend_o) else $error("tick set");
	AST_TCLR: assert property (ics && d[25] && !d[26] |-> ##[1:3] !tick_pend_o)
		else $error("tick clear");
	AST_DSET: assert property (ics && d[28] |-> ##[1:3] dsvc_pend_o) else $error("dsvc set");
	AST_DCLR: assert property (ics && d[27] && !d[28] |-> ##[1:3] !dsvc_pend_o)
		else $error("dsvc clear");
	AST_KEY_BAD: assert property (arc && d[31:16] != 16'h05fa |=> !sys_reset_req_o [*3])
		else $error("bad key");
	AST_KEY_OK: assert property (arc && d[31:16] == 16'h05fa && d[2] && avs_byteenable_i == 4'hf
		|-> ##[1:3] sys_reset_req_o)
		else $error("good key");
	AST_UNMAP: assert property (rd && avs_address_i > 4'h3 |-> avs_readdata_o == 32'h0)
		else $error("unmapped");
	// reserved state bits must read zero
	AST_RSV: assert property (rd && avs_address_i == 4'h0 |-> (avs_readdata_o & 32'he1bc0fc0) == 0)
		else $error("reserved");
	cover property (ics && d[26]);
	cover property (arc);
	cover property (sys_reset_req_o);
endmodule // exc_state_chk
bind exc_state_ctrl exc_state_chk i_chk (.*);
`default_nettype wire

//--- testbench/core_model.sv
// core-side model: active number, requests, acceptance
`timescale 1ns/1ps
`default_nettype none
module core_model (
	// controls from the bench and block state
	input wire logic        sys_clk_i, take_i, en_i, tick_pend_o, dsvc_pend_o,
	input wire logic [5:0]  act_i, req_i,
	// core answers toward the block
	output logic     [5:0]  core_prog_status_i,
	output logic     [31:0] core_irq_pend_i, core_irq_en_i,
	output logic            core_tick_ack_i, core_dsvc_ack_i
);
	assign core_prog_status_i = act_i;
	assign core_irq_pend_i = req_i >= 6'h10 ? 32'h1 << (req_i - 6'h10) : 32'h0;
	assign core_irq_en_i = en_i ? 32'hffffffff : 32'h0;
	logic tick_seen, dsvc_seen;
	// one acceptance per rise; pending lags a cycle, so a level test would take three times
	always @(posedge sys_clk_i) begin
		tick_seen <= tick_pend_o;
		dsvc_seen <= dsvc_pend_o;
		core_tick_ack_i <= take_i && tick_pend_o && !tick_seen;
		core_dsvc_ack_i <= take_i && dsvc_pend_o && !dsvc_seen;
	end
endmodule // core_model
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the exception state block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        sys_clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
	logic        tick_pend_o, dsvc_pend_o, sys_reset_req_o, core_tick_ack_i, core_dsvc_ack_i;
	logic        take_i, en_i;
	logic [3:0]  avs_address_i, avs_byteenable_i;
	logic [5:0]  core_prog_status_i, act_i, req_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, core_irq_pend_i, core_irq_en_i;
	logic [31:0] rdata_seen;
	int          failures, checked, resets, acks;
	exc_state_ctrl i_dut (.*);
	core_model     i_core (.*);
	task chk(input string n, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task finish_test;
		if (failures == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// bus cycle: request held until waitrequest is sampled low at a rising edge
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
		rdata_seen = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	// count reset pulses and core acceptances
	always @(posedge sys_clk_i) begin
		if (sys_reset_req_o === 1'b1)
			resets++;
		if (core_tick_ack_i === 1'b1)
			acks++;
		if (core_dsvc_ack_i === 1'b1)
			acks++;
	end
	// masked read compare, after status settles
	task rd(input string n, input logic [3:0] a, input logic [31:0] m, e);
		repeat (3) @(posedge sys_clk_i);
		acc(1'b0, a, 32'h0);
		chk(n, rdata_seen & m, e);
	endtask
	task t_reset;
		chk("wait", avs_waitrequest_o, 1'b1);
		rd("state", 4'h0, 32'hf7ffffff, 32'h0);
		rd("unmapped", 4'h7, 32'hffffffff, 32'h0);
	endtask
	// set and clear never share one write
	task t_pend;
		acc(1'b1, 4'h0, 32'h04000000);
		rd("tick", 4'h0, 32'h0443f000, 32'h0440f000);
		acc(1'b1, 4'h0, 32'h10000000);
		rd("dsvc", 4'h0, 32'h1443f000, 32'h1440e000);
		acc(1'b1, 4'h0, 32'h08000000);
		rd("dsvc clr", 4'h0, 32'h1443f000, 32'h0440f000);
		acc(1'b1, 4'h0, 32'h02000000);
		rd("tick clr", 4'h0, 32'h1443f000, 32'h0);
	endtask
	task t_irq;
		act_i <= 6'h23;
		req_i <= 6'h14;
		en_i <= 1'b1;
		rd("irq", 4'h0, 32'h0043f03f, 32'h00414023);
		en_i <= 1'b0;
		rd("disabled", 4'h0, 32'h0043f03f, 32'h00400023);
		act_i <= 6'h0;
		req_i <= 6'h0;
		rd("thread", 4'h0, 32'h0043f03f, 32'h0);
	endtask
	task t_key;
		acc(1'b1, 4'h1, 32'h12340004);
		rd("no reset", 4'h2, 32'h4, 32'h0);
		acc(1'b1, 4'h1, 32'h05fa0004);
		rd("reset", 4'h2, 32'h4, 32'h4);
		chk("reset pulses", resets, 1);
	endtask
	// mask bit one lets the status bit through
	task t_int;
		rd("status", 4'h2, 32'h7, 32'h7);
		chk("masked", irq_o, 1'b0);
		acc(1'b1, 4'h3, 32'h7);
		rd("mask", 4'h3, 32'h7, 32'h7);
		repeat (3) @(posedge sys_clk_i);
		chk("irq", irq_o, 1'b1);
		acc(1'b1, 4'h2, 32'h7);
		rd("cleared", 4'h2, 32'h7, 32'h0);
		chk("irq off", irq_o, 1'b0);
	endtask
	// core takes the tick and the deferred request, both pendings must drop
	task t_ack;
		take_i <= 1'b1;
		acc(1'b1, 4'h0, 32'h14000000);
		repeat (4) @(posedge sys_clk_i);
		rd("taken", 4'h0, 32'h14000000, 32'h0);
		chk("acks", acks, 2);
		take_i <= 1'b0;
	endtask
	initial begin
		sys_clk_i = 0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		{failures, checked, resets, acks} = 0;
		{avs_read_i, avs_write_i, take_i, en_i, act_i, req_i} = 0;
		{avs_address_i, avs_writedata_i} = 0;
		avs_byteenable_i = 4'hf;
		rst_i = 1'b1;
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_pend;
		t_irq;
		t_key;
		t_int;
		t_ack;
		finish_test;
	end
	// watchdog against a hung handshake
	initial begin
		repeat (3000) @(posedge sys_clk_i);
		failures++;
		finish_test;
	end
endmodule // tb
`default_nettype wire
